// ### aoc_calib.sv
// Offset and gain calibration logic with its serial register frame decoder
`timescale 1ns/10ps

module aoc_calib (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Serial link from the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_powerdown_pin_i,
  input wire logic cal_i,
  // Raw conversion results, valid when the frame reaches its 19th clock
  input wire aoc_pkg::aoc_pair_t raw_i,
  // Corrected results
  output aoc_pkg::aoc_pair_t res_o,
  output logic res_vld_o,
  output logic res_bad_o,
  // Analog front-end control
  output logic short_in_o,
  output logic conv_busy_o,
  output logic [aoc_pkg::CTRL_PGA_W-1:0] pga_gain_o,
  // Register readback word
  output logic [aoc_pkg::RES_W-1:0] readback_o
);
  import aoc_pkg::*;

  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************

  // Offset removal, gain scaling and saturation of one result
  function automatic logic signed [RES_W-1:0] aoc_corr(
    input logic signed [RES_W-1:0] raw,
    input logic [OFS_W-1:0] ofs,
    input logic [GAIN_W-1:0] gain
  );
    logic signed [SUM_W-1:0] ofs_v;
    logic signed [SUM_W-1:0] diff;
    logic signed [PROD_W-1:0] prod;
    logic signed [SUM_W-1:0] adj;
    logic signed [SUM_W-1:0] y;
    logic signed [RES_W-1:0] out;
    // Offset is sign plus magnitude
    ofs_v = $signed({5'h00, ofs[MAG_W-1:0]});
    if (ofs[OFS_W-1]) begin
      ofs_v = -ofs_v;
    end
    // Old offset stays applied until a new one lands
    diff = SUM_W'(raw) - ofs_v;
    // Magnitude steps of 1/4096 of the offset-free value
    prod = PROD_W'(diff) * $signed({1'b0, gain[GMAG_W-1:0]});
    adj = SUM_W'(prod >>> GAIN_SHIFT);
    // Zero magnitude leaves the value untouched
    if (gain[GAIN_W-1]) begin
      y = diff + adj;
    end else begin
      y = diff - adj;
    end
    // Clamp rather than wrap at the code range ends
    if (y > SAT_HI) begin
      out = RES_W'(SAT_HI);
    end else if (y < SAT_LO) begin
      out = RES_W'(SAT_LO);
    end else begin
      out = RES_W'(y);
    end
    return out;
  endfunction : aoc_corr

  // Turn a shorted-input code into a sign plus magnitude offset
  function automatic logic [OFS_W-1:0] aoc_to_ofs(input logic signed [RES_W-1:0] raw);
    logic [RES_W-1:0] mag;
    mag = raw[RES_W-1] ? RES_W'(-raw) : RES_W'(raw);
    // Eleven magnitude bits cover well past 500 LSB
    if (mag > RES_W'(OFS_MAG_MAX)) begin
      mag = RES_W'(OFS_MAG_MAX);
    end
    return {raw[RES_W-1], mag[MAG_W-1:0]};
  endfunction : aoc_to_ofs

  // ****************************************************************
  // Link clock domain
  // ****************************************************************

  aoc_link_t lnk_q;
  aoc_link_t lnk_d;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic frame_rst_n;
  logic wr_tgl_q;
  logic wr_tgl_d;
  logic done_tgl_q;
  logic done_tgl_d;

  // Frame state dies with select high, since the link clock stops then
  assign frame_rst_n = rst_n_i & ~cs_n_i;

  // Edge counter, shifter and per-frame event flags
  always_comb begin
    lnk_d = lnk_q;
    shift_d = shift_q;
    if (lnk_q.cnt != CNT_SAT) begin
      lnk_d.cnt = lnk_q.cnt + 6'h01;
    end
    // Address then data, first bit first, on edges 1 to 16
    if (lnk_q.cnt < WORD_CLKS) begin
      shift_d = {shift_q[WORD_W-2:0], serial_in_powerdown_pin_i};
    end
    // Write lands on the 17th edge
    if (lnk_q.cnt == WRITE_CLKS - 6'h01) begin
      lnk_d.wr_flag = 1'b1;
    end
    // Conversion or calibration ends on the 19th edge
    if (lnk_q.cnt == CONV_CLKS - 6'h01) begin
      lnk_d.done_flag = 1'b1;
    end
    // Flags die with select, so each event also flips a toggle that outlives the frame
    wr_tgl_d = wr_tgl_q ^ (lnk_d.wr_flag & ~lnk_q.wr_flag);
    done_tgl_d = done_tgl_q ^ (lnk_d.done_flag & ~lnk_q.done_flag);
  end

  // Counter and flags, cleared asynchronously between frames
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // Shift word and toggles survive select high so the core can read them afterwards
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
      wr_tgl_q <= 1'b0;
      done_tgl_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      wr_tgl_q <= wr_tgl_d;
      done_tgl_q <= done_tgl_d;
    end
  end

  // ****************************************************************
  // Core clock domain
  // ****************************************************************

  aoc_core_t c_q;
  aoc_core_t c_d;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] ev_rise;
  logic [NSYNC-1:0] ev_fall;
  logic cal_req;
  logic [ADDR_W-1:0] wr_addr;
  logic [CTRL_W-1:0] wr_data;
  logic [OFS_W-1:0] cap_a;
  logic [OFS_W-1:0] cap_b;
  logic signed [RES_W-1:0] corr_a;
  logic signed [RES_W-1:0] corr_b;

  // Foreign levels; select may rise right after the last edge, so link events cross as toggles
  assign sync_in[SYN_CS] = cs_n_i;
  assign sync_in[SYN_CAL] = cal_i;
  assign sync_in[SYN_WR] = wr_tgl_q;
  assign sync_in[SYN_DONE] = done_tgl_q;

  // Shift word is stable once the write flag has been seen
  assign wr_addr = shift_q[WORD_W-1:WORD_W-ADDR_W];
  assign wr_data = shift_q[CTRL_W-1:0];

  // Corrected and captured values for the current raw pair
  assign corr_a = aoc_corr(raw_i.res_a, c_q.regs.ofs_a, c_q.regs.gain_a);
  assign corr_b = aoc_corr(raw_i.res_b, c_q.regs.ofs_b, c_q.regs.gain_b);
  assign cap_a = aoc_to_ofs(raw_i.res_a);
  assign cap_b = aoc_to_ofs(raw_i.res_b);

  // Calibration requested by pin or by the control bit
  assign cal_req = c_q.lvl[SYN_CAL] | c_q.regs.ctrl[CTRL_CAL_BIT];

  // Next-state logic of the core
  always_comb begin
    c_d = c_q;
    ev_rise = '0;
    ev_fall = '0;
    c_d.res_vld = 1'b0;

    // Three stages; a change counts once stages two and three agree
    for (int i = 0; i < NSYNC; i++) begin
      c_d.sync[i] = {c_q.sync[i][1:0], sync_in[i]};
      if (c_q.sync[i][1] == c_q.sync[i][2]) begin
        c_d.lvl[i] = c_q.sync[i][2];
      end
      ev_rise[i] = c_d.lvl[i] & ~c_q.lvl[i];
      ev_fall[i] = ~c_d.lvl[i] & c_q.lvl[i];
    end

    // Toggle slots: either edge of the level is one link event
    ev_rise[SYN_WR] = c_d.lvl[SYN_WR] ^ c_q.lvl[SYN_WR];
    ev_rise[SYN_DONE] = c_d.lvl[SYN_DONE] ^ c_q.lvl[SYN_DONE];

    // End of a frame: store offsets or deliver a corrected pair
    if (ev_rise[SYN_DONE]) begin
      unique case (c_q.st)
        AOC_CAL: begin
          c_d.regs.ofs_a = cap_a;
          c_d.regs.ofs_b = cap_b;
        end
        AOC_CONV: begin
          c_d.res.res_a = corr_a;
          c_d.res.res_b = corr_b;
          c_d.res_vld = 1'b1;
          c_d.res_bad = c_q.bad | ev_rise[SYN_CAL];
        end
        AOC_IDLE: begin
        end
      endcase
      c_d.st = AOC_IDLE;
    end else if (ev_rise[SYN_CS]) begin
      // Frame cut short: nothing is stored
      c_d.st = AOC_IDLE;
    end

    // Select falling starts a calibration or a normal conversion
    if (ev_fall[SYN_CS]) begin
      c_d.bad = 1'b0;
      if (cal_req) begin
        // Every frame is a fresh measurement, so a spoilt one heals while the pin stays high
        c_d.st = AOC_CAL;
        c_d.regs.ctrl[CTRL_CAL_BIT] = 1'b0;
      end else begin
        c_d.st = AOC_CONV;
      end
    end

    // Request pin rising inside a conversion spoils it
    if ((c_q.st == AOC_CONV) && ev_rise[SYN_CAL]) begin
      c_d.bad = 1'b1;
    end

    // Register write from the frame; written after the clear so a set wins
    if (ev_rise[SYN_WR]) begin
      unique case (wr_addr)
        ADR_CTRL: begin
          c_d.regs.ctrl = wr_data;
          if (wr_data[CTRL_CAL_BIT] && (c_q.st == AOC_CONV)) begin
            c_d.bad = 1'b1;
          end
        end
        ADR_OFS_A: c_d.regs.ofs_a = wr_data;
        ADR_OFS_B: c_d.regs.ofs_b = wr_data;
        // Gain takes the seven bits right after the address
        ADR_GAIN_A: c_d.regs.gain_a = wr_data[CTRL_W-1:CTRL_W-GAIN_W];
        ADR_GAIN_B: c_d.regs.gain_b = wr_data[CTRL_W-1:CTRL_W-GAIN_W];
        default: begin
        end
      endcase
    end

    // Readback word follows the select field of the control register
    unique case (c_q.regs.ctrl[CTRL_RD_LSB +: ADDR_W])
      ADR_RESULT: c_d.rdbk = c_q.res.res_a;
      ADR_CTRL: c_d.rdbk = {2'h0, c_q.regs.ctrl};
      ADR_OFS_A: c_d.rdbk = {2'h0, c_q.regs.ofs_a};
      ADR_OFS_B: c_d.rdbk = {2'h0, c_q.regs.ofs_b};
      ADR_GAIN_A: c_d.rdbk = {7'h00, c_q.regs.gain_a};
      ADR_GAIN_B: c_d.rdbk = {7'h00, c_q.regs.gain_b};
      default: c_d.rdbk = '0;
    endcase
  end

  // Core state register; all corrections start at zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_q.sync <= 12'h007; // Select idles high, the other levels low
      c_q.lvl <= 4'h1;
      c_q.st <= AOC_IDLE;
      c_q.bad <= 1'b0;
      c_q.regs.ctrl <= CTRL_RST;
      c_q.regs.ofs_a <= OFS_RST;
      c_q.regs.ofs_b <= OFS_RST;
      c_q.regs.gain_a <= GAIN_RST;
      c_q.regs.gain_b <= GAIN_RST;
      c_q.res <= '0;
      c_q.res_vld <= 1'b0;
      c_q.res_bad <= 1'b0;
      c_q.rdbk <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Shorting starts a few core cycles after select falls
  assign short_in_o = (c_q.st == AOC_CAL);
  assign conv_busy_o = (c_q.st != AOC_IDLE);
  assign res_o = c_q.res;
  assign res_vld_o = c_q.res_vld;
  assign res_bad_o = c_q.res_bad;
  assign pga_gain_o = c_q.regs.ctrl[CTRL_PGA_W-1:0];
  assign readback_o = c_q.rdbk;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking aoc_cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_pin_cal_start: assert property (
    ev_fall[SYN_CS] && c_q.lvl[SYN_CAL] |=> (c_q.st == AOC_CAL) && short_in_o)
    else $error("calibration did not start with request pin high");

  a_normal_start: assert property (
    ev_fall[SYN_CS] && !cal_req |=> (c_q.st == AOC_CONV) && !short_in_o)
    else $error("normal conversion did not start");

  a_cal_holds: assert property (
    (c_q.st == AOC_CAL) && !ev_rise[SYN_DONE] && !ev_rise[SYN_CS] |=> c_q.st == AOC_CAL)
    else $error("calibration ended before the frame end");

  a_cal_store: assert property (
    (c_q.st == AOC_CAL) && ev_rise[SYN_DONE]
      |=> (c_q.regs.ofs_a == $past(cap_a)) && (c_q.regs.ofs_b == $past(cap_b))
        && (c_q.st == AOC_IDLE) && !res_vld_o)
    else $error("offset not stored at calibration end");

  a_bit_start: assert property (
    ev_fall[SYN_CS] && c_q.regs.ctrl[CTRL_CAL_BIT] && !ev_rise[SYN_WR]
      |=> (c_q.st == AOC_CAL) && !c_q.regs.ctrl[CTRL_CAL_BIT])
    else $error("control bit did not start a calibration");

  a_pin_corrupt: assert property (
    (c_q.st == AOC_CONV) && ev_rise[SYN_CAL] && !ev_rise[SYN_DONE] |=> c_q.bad)
    else $error("pin rise during conversion not flagged");

  a_res_pulse: assert property (
    (c_q.st == AOC_CONV) && ev_rise[SYN_DONE]
      |=> res_vld_o && (res_o.res_a == $past(corr_a)) ##1 !res_vld_o)
    else $error("corrected result not delivered as one pulse");

  a_ofs_write: assert property (
    ev_rise[SYN_WR] && (wr_addr == ADR_OFS_B) && !ev_rise[SYN_DONE]
      |=> c_q.regs.ofs_b == $past(wr_data))
    else $error("offset register write lost");

  a_gain_write: assert property (
    ev_rise[SYN_WR] && (wr_addr == ADR_GAIN_A)
      |=> (c_q.regs.gain_a == $past(wr_data[CTRL_W-1:CTRL_W-GAIN_W]))
        && $stable(c_q.regs.gain_b))
    else $error("gain register write wrong");

  a_gain_unity: assert property (
    (c_q.regs.gain_a[GMAG_W-1:0] == 6'h00) && (c_q.regs.ofs_a == OFS_RST)
      |-> corr_a == raw_i.res_a)
    else $error("zero gain and offset changed the result");

  a_bit_corrupt: assert property (
    ev_rise[SYN_WR] && (wr_addr == ADR_CTRL) && wr_data[CTRL_CAL_BIT]
      && (c_q.st == AOC_CONV)
      |=> c_q.bad)
    else $error("control bit write during conversion not flagged");

  a_cut_frame: assert property (
    ev_rise[SYN_CS] && !ev_rise[SYN_DONE]
      |=> (c_q.st == AOC_IDLE) && !res_vld_o)
    else $error("cut frame left the core busy or gave a result");

  c_cal_frame: cover property (
    (c_q.st == AOC_CAL) && ev_rise[SYN_DONE]);
  c_conv_frame: cover property (
    (c_q.st == AOC_CONV) && ev_rise[SYN_DONE] ##1 res_vld_o && !res_bad_o);
  c_bad_frame: cover property (res_vld_o && res_bad_o);
  c_gain_write: cover property (ev_rise[SYN_WR] && (wr_addr == ADR_GAIN_B));
  c_cut_frame: cover property (ev_rise[SYN_CS] && (c_q.st == AOC_CONV));

endmodule : aoc_calib

// ### aoc_pkg.sv
// Constants and types for the converter offset and gain calibration block
//
// Behaviour
// - Request pin high starts calibration at select fall
// - Calibration lasts one frame of 19 clocks
// - Pin held high keeps calibrating every frame
// - Early select rise spoils only that calibration
// - Pin rising mid-conversion marks result corrupted
// - Calibration completes after the 19th clock
// - First frame after pin low converts normally
// - Control bit write starts calibration, corrupts conversion
// - Calibration stores shorted-input code as offset
// - Stored offset subtracted from every later result
// - Old offset kept until recalibration after gain change
// - Offset correction covers at least 500 LSB
// - Written offset applies without any calibration
// - Each channel has its own gain register
// - Gain register is sign plus six-bit magnitude
// - Each magnitude step is one part in 4096
// - All-zero gain register applies no scaling
// - Sign 0 reduces, sign 1 increases the multiplier
// - Register write completes on the 17th clock
// - Offset and gain registers reset to zero
package aoc_pkg;

  // Widths
  localparam int RES_W = 14;
  localparam int OFS_W = 12;
  localparam int MAG_W = 11;
  localparam int GAIN_W = 7;
  localparam int GMAG_W = 6;
  localparam int CTRL_W = 12;
  localparam int ADDR_W = 4;
  localparam int WORD_W = 16;
  localparam int CNT_W = 6;
  localparam int SUM_W = 16;
  localparam int PROD_W = 23;
  localparam int NSYNC = 4;

  // Serial frame counts, in link clock falling edges
  localparam logic [CNT_W-1:0] WORD_CLKS = 6'h10;
  localparam logic [CNT_W-1:0] WRITE_CLKS = 6'h11;
  localparam logic [CNT_W-1:0] CONV_CLKS = 6'h13;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h3F;

  // Register addresses carried in the first four bits of a frame
  localparam logic [ADDR_W-1:0] ADR_RESULT = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_OFS_A = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_OFS_B = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_GAIN_A = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_GAIN_B = 4'h5;

  // Control register fields
  localparam int CTRL_RD_LSB = 8;
  localparam int CTRL_CAL_BIT = 4;
  localparam int CTRL_PGA_W = 4;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [OFS_W-1:0] OFS_RST = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_RST = 7'h00;

  // Arithmetic limits
  localparam int GAIN_SHIFT = 12;
  localparam logic [MAG_W-1:0] OFS_MAG_MAX = 11'h7FF;
  localparam logic signed [SUM_W-1:0] SAT_HI = 16'sh1FFF;
  localparam logic signed [SUM_W-1:0] SAT_LO = 16'shE000;

  // Synchroniser slots
  localparam int SYN_CS = 0;
  localparam int SYN_CAL = 1;
  localparam int SYN_WR = 2;
  localparam int SYN_DONE = 3;

  typedef enum logic [1:0] {
    AOC_IDLE = 2'b00,
    AOC_CONV = 2'b01,
    AOC_CAL = 2'b10
  } aoc_state_t;

  typedef struct packed {
    logic signed [RES_W-1:0] res_a;
    logic signed [RES_W-1:0] res_b;
  } aoc_pair_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [OFS_W-1:0] ofs_a;
    logic [OFS_W-1:0] ofs_b;
    logic [GAIN_W-1:0] gain_a;
    logic [GAIN_W-1:0] gain_b;
  } aoc_regs_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic wr_flag;
    logic done_flag;
  } aoc_link_t;

  typedef struct packed {
    logic [NSYNC-1:0][2:0] sync;
    logic [NSYNC-1:0] lvl;
    aoc_state_t st;
    logic bad;
    aoc_regs_t regs;
    aoc_pair_t res;
    logic res_vld;
    logic res_bad;
    logic [RES_W-1:0] rdbk;
  } aoc_core_t;

endpackage : aoc_pkg

// ### aoc_host_model.sv
// Host model driving the serial link, frame select and trim request pin
`timescale 1ns/10ps

module aoc_host_model (
  // Core clock, used only to pick a start time
  input wire logic mclk_i,
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  output logic cal_o
);

  // ****************
  // Link host
  // ****************

  // Idle link: clock parked high, select off
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b1;
    cal_o = 1'b0;
  end

  // Request pin moves here with select high, then settles before any frame; frame raises it mid-frame at cal_at
  task automatic set_cal(input logic v);
    @(negedge mclk_i);
    cal_o = v;
    #300;
  endtask : set_cal

  // Word bits ahead of falling edges 1..16, low after; power-down never asked
  task automatic frame(input logic [15:0] word, input int nclk, input int cal_at);
    @(negedge mclk_i);
    #7;
    cs_n_o = 1'b0;
    din_o = word[15];
    for (int n = 1; n <= nclk; n++) begin
      #15;
      sclk_o = 1'b0;
      if (n == cal_at) cal_o = 1'b1;
      #15;
      sclk_o = 1'b1;
      din_o = (n < 16) ? word[15-n] : 1'b0;
    end
    #15;
    cs_n_o = 1'b1;
    // Released data line shows the inverse so stale bits never look valid
    din_o = ~din_o;
    #400;
  endtask : frame

endmodule : aoc_host_model

// ### aoc_calib_bench.sv
// Self-checking bench for the converter offset and gain calibration block
`timescale 1ns/10ps

module aoc_calib_bench;
  import aoc_pkg::*;

  typedef struct packed {
    aoc_pair_t pair;
    logic bad;
  } aoc_exp_t;

  // ****************
  // Signals and model state
  // ****************
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sclk, cs_n, din, cal;
  aoc_pair_t raw_i = '0;
  aoc_pair_t res_o;
  logic res_vld_o, res_bad_o, short_in_o, conv_busy_o;
  logic [3:0] pga_gain_o;
  logic [13:0] readback_o;
  aoc_exp_t exp_q[$];
  aoc_exp_t exp_e;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 32'hC096;
  logic [11:0] ofs_a = 12'h000;
  logic [11:0] ofs_b = 12'h000;
  logic [6:0] gain_a = 7'h00;
  logic [6:0] gain_b = 7'h00;
  logic seen_short = 1'b0;
  logic seen_busy = 1'b0;
  logic [13:0] mean = 14'h1FA4;
  logic [13:0] gtab [4] = '{14'h3FC1, 14'h00BF, 14'h2000, 14'h0000};

  // 20 MHz core clock
  always #25 mclk_i = ~mclk_i;

  aoc_host_model host_u (.mclk_i(mclk_i), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .cal_o(cal));

  aoc_calib dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_powerdown_pin_i(din), .cal_i(cal), .raw_i(raw_i), .res_o(res_o),
    .res_vld_o(res_vld_o), .res_bad_o(res_bad_o), .short_in_o(short_in_o),
    .conv_busy_o(conv_busy_o), .pga_gain_o(pga_gain_o), .readback_o(readback_o));

  // ****************
  // Reference arithmetic
  // ****************
  function automatic logic [13:0] corr(input int raw, input logic [11:0] o, input logic [6:0] g);
    int y;
    int p;
    y = raw - (o[11] ? -int'(o[10:0]) : int'(o[10:0]));
    p = (y * int'(g[5:0])) >>> 12;
    y = g[6] ? y + p : y - p;
    if (y > 8191) y = 8191;
    if (y < -8192) y = -8192;
    return y[13:0];
  endfunction : corr

  // Shorted-input code to sign and magnitude, magnitude clamped
  function automatic logic [11:0] sm(input int r);
    int m;
    m = (r < 0) ? -r : r;
    if (m > 2047) m = 2047;
    return {r < 0, m[10:0]};
  endfunction : sm

  function automatic int rnd();
    return $random(seed) % 8192;
  endfunction : rnd

  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : chk

  // Converter codes change only between frames, at the falling edge
  task automatic set_raw(input int a, input int b);
    @(negedge mclk_i);
    raw_i.res_a = a[13:0];
    raw_i.res_b = b[13:0];
    seen_short = 1'b0;
    seen_busy = 1'b0;
  endtask : set_raw

  task automatic conv(input int a, input int b, input logic bad, input logic [15:0] w,
    input int cal_at);
    set_raw(a, b);
    exp_q.push_back({corr(a, ofs_a, gain_a), corr(b, ofs_b, gain_b), bad});
    host_u.frame(w, 19, cal_at);
    chk({seen_busy, seen_short} === 2'b10, "normal frame flags");
  endtask : conv

  task automatic calib(input int a, input int b);
    set_raw(a, b);
    host_u.frame(16'h0000, 19, 0);
    chk({seen_busy, seen_short} === 2'b11, "calibration flags");
    ofs_a = sm(a);
    ofs_b = sm(b);
  endtask : calib

  task automatic wreg(input logic [3:0] adr, input logic [11:0] d);
    host_u.frame({adr, d}, 17, 0);
  endtask : wreg

  task automatic rd(input logic [3:0] sel, input logic [13:0] e);
    wreg(ADR_CTRL, {sel, 8'h00});
    @(negedge mclk_i);
    chk(readback_o === e, "readback word");
  endtask : rd

  // Result watcher at mid-cycle, where registered outputs have settled
  always @(negedge mclk_i) begin
    if (short_in_o === 1'b1) seen_short = 1'b1;
    if (conv_busy_o === 1'b1) seen_busy = 1'b1;
    if (res_vld_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1'b0, "result without a conversion");
      end else begin
        exp_e = exp_q.pop_front();
        chk({res_o, res_bad_o} === exp_e, "corrected result or flag");
      end
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (5) @(negedge mclk_i);
    chk({res_vld_o, short_in_o, conv_busy_o, pga_gain_o, readback_o} === '0, "reset");
    for (int s = 2; s < 6; s++) rd(s[3:0], 14'h0000);
    repeat (3) conv(rnd(), rnd(), 1'b0, 16'h0000, 0);
    // Host-loaded offsets, one packed from a 14-bit mean
    ofs_a = {mean[13], mean[10:0]};
    ofs_b = 12'h9F4;
    wreg(ADR_OFS_A, ofs_a);
    wreg(ADR_OFS_B, ofs_b);
    rd(4'h2, 14'h07A4);
    rd(4'h3, 14'h09F4);
    repeat (3) conv(rnd(), rnd(), 1'b0, 16'h0000, 0);
    // Both full-scale codes measured before any gain is chosen
    conv(8191, -8192, 1'b0, 16'h0000, 0);
    // Gain pairs per channel, ending with both cleared
    foreach (gtab[i]) begin
      gain_a = gtab[i][13:7];
      gain_b = gtab[i][6:0];
      wreg(ADR_GAIN_A, {gain_a, 5'h00});
      wreg(ADR_GAIN_B, {gain_b, 5'h00});
      rd(4'h4, {7'h00, gain_a});
      rd(4'h5, {7'h00, gain_b});
      conv(rnd(), rnd(), 1'b0, 16'h0000, 0);
    end
    // Both ends of the code range
    ofs_a = 12'h8F0;
    ofs_b = 12'h100;
    gain_a = 7'h7F;
    gain_b = 7'h7F;
    wreg(ADR_OFS_A, ofs_a);
    wreg(ADR_OFS_B, ofs_b);
    wreg(ADR_GAIN_A, 12'hFE0);
    wreg(ADR_GAIN_B, 12'hFE0);
    conv(8191, -8192, 1'b0, 16'h0000, 0);
    // Unmapped address and a short frame change nothing
    wreg(4'h7, 12'hFFF);
    host_u.frame({ADR_OFS_A, 12'h123}, 16, 0);
    rd(4'h2, {2'b00, ofs_a});
    rd(4'h4, {7'h00, gain_a});
    // Amplifier gain change keeps the old offset
    wreg(ADR_CTRL, 12'h10A);
    @(negedge mclk_i);
    chk(pga_gain_o === 4'hA && readback_o === 14'h010A, "control word");
    conv(rnd(), rnd(), 1'b0, 16'h0000, 0);
    // Calibration by pin, held over two frames
    host_u.set_cal(1'b1);
    calib(rnd(), rnd());
    calib(rnd(), rnd());
    host_u.set_cal(1'b0);
    rd(4'h2, {2'b00, ofs_a});
    rd(4'h3, {2'b00, ofs_b});
    conv(rnd(), rnd(), 1'b0, 16'h0000, 0);
    // Pin raised inside a conversion spoils it, next frame calibrates
    conv(rnd(), rnd(), 1'b1, 16'h0000, 12);
    calib(rnd(), rnd());
    host_u.set_cal(1'b0);
    conv(rnd(), rnd(), 1'b0, 16'h0000, 0);
    // Control bit request, then the bit clears itself
    conv(rnd(), rnd(), 1'b1, {ADR_CTRL, 12'h010}, 0);
    calib(rnd(), rnd());
    conv(rnd(), rnd(), 1'b0, 16'h0000, 0);
    rd(4'h3, {2'b00, ofs_b});
    report_and_stop();
  end

  // Watchdog, well beyond the roughly 60 frames above
  initial begin
    #400000;
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop();
  end

  task automatic report_and_stop();
    if (exp_q.size() != 0) mismatches++;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

endmodule : aoc_calib_bench
